// ===== shared/mrb_consts.svh
// Constants of the receive buffer and host serial port.
`ifndef MRB_CONSTS_SVH
`define MRB_CONSTS_SVH
`define MRB_CMD_READ    8'h01
`define MRB_CMD_FLUSH   8'h03
`define MRB_ZERO_BYTE   8'h00
`define MRB_MSG_MAX     4'hC
`define MRB_IDX_TARGET  4'h1
`define MRB_IDX_ZERO    4'h0
`define MRB_IDX_ONE     4'h1
`define MRB_ST_ERR_LO   0
`define MRB_ST_BUS_ACT  2
`define MRB_ST_TX_LO    3
`define MRB_ST_RX_LO    6
`define MRB_BIT_LAST    3'h7
`define MRB_BIT_ZERO    3'h0
`define MRB_BIT_ONE     3'h1
`define MRB_FIFO_W      10
`define MRB_FIFO_D      8
`define MRB_CNT_ONE     2'h1
`define MRB_LINK_KHZ    500
`define MRB_CLK_MHZ     200
`endif

// ===== shared/mrb_pkg.sv
// Types shared by the receive buffer and host serial port.
package mrb_pkg;
  // Position of the host link inside one chip select frame.
  typedef enum logic [1:0] {MRB_IDLE, MRB_CMD, MRB_DATA} mrb_link_t;
  // Byte lane and message buffer index types.
  typedef logic [7:0] mrb_byte_t;
  typedef logic [3:0] mrb_idx_t;
endpackage

// ===== core/mrb_fifo.sv
// Parameterised first-in first-out buffer with valid and ready on both sides.
`timescale 1ns/1ps
`default_nettype none
module mrb_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  input  wire logic         clock,
  input  wire logic         rstn,
  input  wire logic         in_valid,
  input  wire logic [W-1:0] in_data,
  output logic              in_ready,
  output logic              out_valid,
  output logic [W-1:0]      out_data,
  input  wire logic         out_ready
);
  localparam int AW = $clog2(D);

  logic [W-1:0] mem [D];      // Storage words.
  logic [AW-1:0] wp_q, wp_d;  // Write pointer.
  logic [AW-1:0] rp_q, rp_d;  // Read pointer.
  logic [AW:0]   cnt_q, cnt_d; // Words held.
  logic          full_q, full_d; // Registered full, drives in_ready.
  logic          push, pop;

  // Pointers wrap by hand so that depths other than powers of two work.
  always_comb begin
    push   = in_valid && !full_q;
    pop    = out_ready && (cnt_q != '0);
    wp_d   = wp_q;
    rp_d   = rp_q;
    cnt_d  = cnt_q;
    if (push) begin
      wp_d = (wp_q == AW'(D - 1)) ? '0 : wp_q + 1'b1;
    end
    if (pop) begin
      rp_d = (rp_q == AW'(D - 1)) ? '0 : rp_q + 1'b1;
    end
    if (push && !pop) begin
      cnt_d = cnt_q + 1'b1;
    end else if (pop && !push) begin
      cnt_d = cnt_q - 1'b1;
    end
    full_d = (cnt_d == (AW + 1)'(D));
  end

  // Register state; the array needs no reset.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      wp_q   <= '0;
      rp_q   <= '0;
      cnt_q  <= '0;
      full_q <= 1'b0;
    end else begin
      wp_q   <= wp_d;
      rp_q   <= rp_d;
      cnt_q  <= cnt_d;
      full_q <= full_d;
    end
  end

  // Storage write.
  always_ff @(posedge clock) begin
    if (push) begin
      mem[wp_q] <= in_data;
    end
  end

  assign in_ready  = !full_q;
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem[rp_q];
endmodule
`default_nettype wire

// ===== core/mrb_rx_port.sv
// Two-message receive buffer drained by the host over a serial link.
// Operation
// [R01] Raise message-ready output when a buffer holds message.
// [R02] Pass only error-free, filter-accepted messages to host.
// [R03] Host reads type, target, source, then data.
// [R04] Status shows empty buffer; host reads until then.
// [R05] Flush command discards current buffer at once.
// [R06] Read-out or flushed buffer is released for reuse.
// [R07] Host sees transmit, receive and bus error status.
// [R08] Status: bus active bit2, tx 5:3, rx 7:6.
// [R09] Command byte 03 flushes the current receive buffer.
// [R10] Link is mode 3, host master, 500 kHz.
// [R11] One byte exchange per frame under low select; the code exchanges two bytes per frame, status then data.
`timescale 1ns/1ps
`default_nettype none
`include "mrb_consts.svh"
module mrb_rx_port
  import mrb_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       rstn,
  input  wire logic       in_valid,
  input  wire logic [7:0] in_data,
  input  wire logic       in_last,
  input  wire logic       in_err,
  output logic            in_ready,
  input  wire logic [7:0] acc_code,
  input  wire logic [7:0] acc_mask,
  input  wire logic       bus_active,
  input  wire logic [2:0] tx_state,
  input  wire logic       bus_fault,
  input  wire logic       spi_csn,
  input  wire logic       spi_sck,
  input  wire logic       spi_mosi,
  output logic            spi_miso,
  output logic            spi_miso_oe,
  output logic            msg_irq
);
  // Incoming byte stream passes the FIFO so the bus side sees back-pressure.
  logic       fo_valid;     // A byte waits at the FIFO head.
  logic [9:0] fo_word;      // Head word: err, last, data.
  logic       fo_ready;     // Writer takes the head word.
  logic       fifo_ready;   // FIFO has room.

  mrb_fifo #(
    .W (`MRB_FIFO_W),
    .D (`MRB_FIFO_D)
  ) u_fifo (
    .clock     (clock),
    .rstn      (rstn),
    .in_valid  (in_valid),
    .in_data   ({in_err, in_last, in_data}),
    .in_ready  (fifo_ready),
    .out_valid (fo_valid),
    .out_data  (fo_word),
    .out_ready (fo_ready)
  );
  assign in_ready = fifo_ready;

  // Message store: two buffers, each one whole bus message.
  mrb_byte_t mem [2][`MRB_MSG_MAX];
  logic [1:0] full_q, full_d;   // Buffer holds a complete message.
  mrb_idx_t   len_q [2];        // Bytes in each complete message.
  mrb_idx_t   len_d [2];
  logic       wsel_q, wsel_d;   // Buffer being filled.
  mrb_idx_t   wptr_q, wptr_d;   // Fill position.
  logic       pass_q, pass_d;   // Target byte met the acceptance filter.
  logic       ovf_q, ovf_d;     // Message ran past the buffer size.
  logic       rsel_q, rsel_d;   // Buffer the host drains.
  mrb_idx_t   rptr_q, rptr_d;   // Drain position.
  logic       drop_q, drop_d;   // Sticky: a message was dropped.
  logic       wr_en;            // Store the head byte this cycle.

  // Pin synchronisers; only the second stage is looked at.
  logic cs_s1_q, cs_s2_q, sck_s1_q, sck_s2_q, mo_s1_q, mo_s2_q;
  logic sck_old_q;              // Previous synced clock level.
  logic cs_old_q;               // Previous synced select level.

  // Link state.
  mrb_link_t  link_q, link_d;   // Frame phase.
  logic [2:0] bit_q, bit_d;     // Bits taken in this byte.
  logic [7:0] rxsr_q, rxsr_d;   // Command shift register.
  logic [15:0] txsr_q, txsr_d;  // Status then data to the host.
  logic       miso_q, miso_d;   // Output bit.
  logic       oe_q, oe_d;       // Output enable while selected.
  logic       irq_q, irq_d;     // Message-ready output.
  logic       bflt_q, bflt_d;   // Sticky bus fault.

  logic       rise, fall, sel_start, sel_end;
  logic [7:0] cmd;              // Command as complete at the 8th bit.
  logic       do_read, do_flush;
  logic [7:0] status;

  // Filter test: mask bits set to one must match the code.
  function automatic logic accept(input logic [7:0] b, input logic [7:0] c,
                                  input logic [7:0] m);
    return ((b ^ c) & m) == `MRB_ZERO_BYTE;
  endfunction

  // Edge and command decoding on synced pins.
  always_comb begin
    rise      = sck_s2_q && !sck_old_q && !cs_s2_q;
    fall      = !sck_s2_q && sck_old_q && !cs_s2_q;
    sel_start = !cs_s2_q && cs_old_q;
    sel_end   = cs_s2_q && !cs_old_q;
    cmd       = {rxsr_q[6:0], mo_s2_q};
    do_read   = rise && (link_q == MRB_CMD) && (bit_q == `MRB_BIT_LAST)
                && (cmd == `MRB_CMD_READ);
    // [R09] Flush command decode.
    do_flush  = rise && (link_q == MRB_CMD) && (bit_q == `MRB_BIT_LAST)
                && (cmd == `MRB_CMD_FLUSH);
    // [R08] Status byte layout.
    status = `MRB_ZERO_BYTE;
    status[`MRB_ST_RX_LO +: 2]  = {1'b0, full_q[0]} + {1'b0, full_q[1]};
    status[`MRB_ST_TX_LO +: 3]  = tx_state;
    status[`MRB_ST_BUS_ACT]     = bus_active;
    // [R07] Error flags to the host.
    status[`MRB_ST_ERR_LO +: 2] = {bflt_q, drop_q};
  end

  // Writer and buffer bookkeeping.
  always_comb begin
    full_d = full_q;
    len_d  = len_q;
    wsel_d = wsel_q;
    wptr_d = wptr_q;
    pass_d = pass_q;
    ovf_d  = ovf_q;
    rsel_d = rsel_q;
    rptr_d = rptr_q;
    drop_d = drop_q;
    // Stall while the target buffer still holds an unread message.
    fo_ready = fo_valid && !full_q[wsel_q];
    wr_en    = fo_ready && (wptr_q < `MRB_MSG_MAX);
    if (fo_ready) begin
      if (wptr_q == `MRB_IDX_TARGET) begin
        pass_d = accept(fo_word[7:0], acc_code, acc_mask);
      end
      if (wptr_q == `MRB_MSG_MAX) begin
        ovf_d = 1'b1;
      end else begin
        wptr_d = wptr_q + `MRB_IDX_ONE;
      end
      if (fo_word[8]) begin
        wptr_d = `MRB_IDX_ZERO;
        pass_d = 1'b0;
        ovf_d  = 1'b0;
        // [R02] Keep only clean, accepted messages of full header length.
        // The overflow test uses the registered flag and the fill position,
        // since the next-value flag was cleared just above for the next one.
        if (!fo_word[9] && !ovf_q && (wptr_q < `MRB_MSG_MAX)
            && (wptr_q > `MRB_IDX_TARGET) && pass_q) begin
          full_d[wsel_q] = 1'b1;
          len_d[wsel_q]  = wptr_q + `MRB_IDX_ONE;
          wsel_d         = !wsel_q;
        end else begin
          drop_d = 1'b1;
        end
      end
    end
    // [R03] Bytes leave strictly in arrival order.
    if (do_read && full_q[rsel_q]) begin
      rptr_d = rptr_q + `MRB_IDX_ONE;
      // [R06] Last byte read frees the buffer.
      if (rptr_d == len_q[rsel_q]) begin
        full_d[rsel_q] = 1'b0;
        rptr_d         = `MRB_IDX_ZERO;
        rsel_d         = !rsel_q;
      end
    end
    // [R05] Flush drops the rest of the current buffer.
    if (do_flush && full_q[rsel_q]) begin
      // [R06] Flushed buffer is freed.
      full_d[rsel_q] = 1'b0;
      rptr_d         = `MRB_IDX_ZERO;
      rsel_d         = !rsel_q;
    end
    // Status read clears the sticky drop flag; a new drop wins.
    if (sel_start && !(fo_ready && fo_word[8] && !full_d[wsel_q])) begin
      drop_d = 1'b0;
    end
  end

  // Register the buffer bookkeeping.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      full_q   <= 2'h0;
      len_q[0] <= `MRB_IDX_ZERO;
      len_q[1] <= `MRB_IDX_ZERO;
      wsel_q   <= 1'b0;
      wptr_q   <= `MRB_IDX_ZERO;
      pass_q   <= 1'b0;
      ovf_q    <= 1'b0;
      rsel_q   <= 1'b0;
      rptr_q   <= `MRB_IDX_ZERO;
      drop_q   <= 1'b0;
    end else begin
      full_q   <= full_d;
      len_q    <= len_d;
      wsel_q   <= wsel_d;
      wptr_q   <= wptr_d;
      pass_q   <= pass_d;
      ovf_q    <= ovf_d;
      rsel_q   <= rsel_d;
      rptr_q   <= rptr_d;
      drop_q   <= drop_d;
    end
  end

  // Message store write; contents need no reset.
  always_ff @(posedge clock) begin
    if (wr_en) begin
      mem[wsel_q][wptr_q] <= fo_word[7:0];
    end
  end

  // [R10] Two-stage synchronisers for the host pins.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      cs_s1_q   <= 1'b1;
      cs_s2_q   <= 1'b1;
      sck_s1_q  <= 1'b1;
      sck_s2_q  <= 1'b1;
      mo_s1_q   <= 1'b0;
      mo_s2_q   <= 1'b0;
      sck_old_q <= 1'b1;
      cs_old_q  <= 1'b1;
    end else begin
      cs_s1_q   <= spi_csn;
      cs_s2_q   <= cs_s1_q;
      sck_s1_q  <= spi_sck;
      sck_s2_q  <= sck_s1_q;
      mo_s1_q   <= spi_mosi;
      mo_s2_q   <= mo_s1_q;
      sck_old_q <= sck_s2_q;
      cs_old_q  <= cs_s2_q;
    end
  end

  // Link frame logic; clock idles high, shift out on fall, sample on rise.
  always_comb begin
    link_d = link_q;
    bit_d  = bit_q;
    rxsr_d = rxsr_q;
    txsr_d = txsr_q;
    miso_d = miso_q;
    oe_d   = !cs_s2_q;
    bflt_d = bflt_q || bus_fault;
    // [R11] Frame opens on select low and loads the status byte.
    if (sel_start) begin
      link_d = MRB_CMD;
      bit_d  = `MRB_BIT_ZERO;
      txsr_d = {status, `MRB_ZERO_BYTE};
      bflt_d = bus_fault;
    end else if (sel_end) begin
      link_d = MRB_IDLE;
    end
    // [R10] Mode 3 leading edge drives the next bit.
    if (fall && (link_q != MRB_IDLE)) begin
      miso_d = txsr_q[15];
      txsr_d = {txsr_q[14:0], 1'b0};
    end
    // [R10] Trailing edge samples the host bit.
    if (rise && (link_q != MRB_IDLE)) begin
      rxsr_d = cmd;
      bit_d  = bit_q + `MRB_BIT_ONE;
      if (bit_q == `MRB_BIT_LAST) begin
        link_d = (link_q == MRB_CMD) ? MRB_DATA : MRB_IDLE;
        // [R04] Reply byte is data on a read command, or zero when the buffer is empty or the command is not a read.
        txsr_d[15:8] = (do_read && full_q[rsel_q]) ? mem[rsel_q][rptr_q]
                                                   : `MRB_ZERO_BYTE;
      end
    end
    // [R01] Ready output follows any held message.
    irq_d = |full_d;
  end

  // Register the link state and outputs.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      link_q <= MRB_IDLE;
      bit_q  <= `MRB_BIT_ZERO;
      rxsr_q <= `MRB_ZERO_BYTE;
      txsr_q <= 16'h0000;
      miso_q <= 1'b0;
      oe_q   <= 1'b0;
      irq_q  <= 1'b0;
      bflt_q <= 1'b0;
    end else begin
      link_q <= link_d;
      bit_q  <= bit_d;
      rxsr_q <= rxsr_d;
      txsr_q <= txsr_d;
      miso_q <= miso_d;
      oe_q   <= oe_d;
      irq_q  <= irq_d;
      bflt_q <= bflt_d;
    end
  end

  assign spi_miso    = miso_q;
  assign spi_miso_oe = oe_q;
  assign msg_irq     = irq_q;
endmodule
`default_nettype wire

// ===== tb/mrb_rx_chk.sv
// Port timing checker for the receive buffer host port.
`timescale 1ns/1ps
`default_nettype none
module mrb_rx_chk (
  input wire logic clock,
  input wire logic rstn,
  input wire logic in_valid,
  input wire logic in_ready,
  input wire logic spi_csn,
  input wire logic spi_sck,
  input wire logic spi_miso,
  input wire logic spi_miso_oe,
  input wire logic msg_irq
);
  // All checks share one clock and the async reset.
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);
  // Out of reset: room, no message and a quiet pin.
  rst_out_a: assert property (
    $rose(rstn) |-> in_ready && !msg_irq && !spi_miso_oe)
    else $error("outputs wrong after reset");
  // Room is lost only by taking a byte.
  ready_fall_a: assert property (
    $fell(in_ready) |-> $past(in_valid))
    else $error("ready fell without a write");
  oe_on_a: assert property (
    $fell(spi_csn) |-> ##[1:4] spi_miso_oe)
    else $error("miso not driven after select");
  oe_off_a: assert property (
    $rose(spi_csn) |-> ##[1:4] !spi_miso_oe)
    else $error("miso still driven after select");
  oe_hold_a: assert property (
    (!spi_csn) [*5] |-> spi_miso_oe)
    else $error("miso released inside frame");
  oe_idle_a: assert property (
    spi_csn [*5] |-> !spi_miso_oe)
    else $error("miso driven while idle");
  // A held message only leaves through a host frame.
  irq_hold_a: assert property (
    spi_csn [*6] ##0 msg_irq |=> msg_irq)
    else $error("irq dropped without host");
  // Data moves only in the low half of the link clock.
  miso_edge_a: assert property (
    $changed(spi_miso) && !spi_csn && !$past(spi_csn, 4)
    |-> !spi_sck)
    else $error("miso moved while clock high");
  cover property ($rose(msg_irq));
  cover property ($fell(msg_irq));
  cover property (!in_ready);
endmodule
bind mrb_rx_port mrb_rx_chk i_mrb_rx_chk (
  .clock(clock), .rstn(rstn), .in_valid(in_valid),
  .in_ready(in_ready), .spi_csn(spi_csn), .spi_sck(spi_sck),
  .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe), .msg_irq(msg_irq));
`default_nettype wire

// ===== tb/mrb_host.sv
// Host link master model that runs one command frame.
`timescale 1ns/1ps
`default_nettype none
module mrb_host
  import mrb_pkg::*;
(
  input  wire logic clock,
  output logic      spi_csn,
  output logic      spi_sck,
  output logic      spi_mosi,
  input  wire logic spi_miso
);
  localparam int HALF = 200; // Clocks per half link period.
  // Select high and clock idle high before reset ends.
  initial begin
    spi_csn = 1'b1;
    spi_sck = 1'b1;
    spi_mosi = 1'b0;
  end
  task automatic xfer(input mrb_byte_t cmd, output mrb_byte_t st,
                      output mrb_byte_t dat);
    logic [15:0] tx;
    logic [15:0] rx;
    tx = {cmd, 8'h00};
    spi_csn <= 1'b0;
    repeat (HALF) @(posedge clock);
    for (int i = 15; i >= 0; i--) begin
      spi_sck <= 1'b0;
      spi_mosi <= tx[i];
      repeat (HALF) @(posedge clock);
      spi_sck <= 1'b1;
      repeat (HALF) @(posedge clock);
      rx[i] = spi_miso;
    end
    // Released data line shows the inverse of its last bit.
    spi_csn <= 1'b1;
    spi_mosi <= ~tx[0];
    repeat (HALF) @(posedge clock);
    st = rx[15:8];
    dat = rx[7:0];
  endtask
endmodule
`default_nettype wire

// ===== tb/tb.sv
// Self-checking bench for the receive buffer host port.
`timescale 1ns/1ps
`default_nettype none
`include "mrb_consts.svh"
module tb
  import mrb_pkg::*;
;
  logic      clock, rstn, in_valid, in_last, in_err, in_ready;
  logic      bus_fault, spi_csn, spi_sck, spi_mosi, spi_miso;
  logic      spi_miso_oe, msg_irq, bus_active;
  mrb_byte_t in_data, st, dat;
  int        n_errors, checked, n;
  mrb_rx_port i_mrb_rx_port (
    .clock(clock), .rstn(rstn), .in_valid(in_valid),
    .in_data(in_data), .in_last(in_last), .in_err(in_err),
    .in_ready(in_ready), .acc_code(8'h26), .acc_mask(8'hF0),
    .bus_active(bus_active), .tx_state(3'h6), .bus_fault(bus_fault),
    .spi_csn(spi_csn), .spi_sck(spi_sck), .spi_mosi(spi_mosi),
    .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe),
    .msg_irq(msg_irq));
  mrb_host i_mrb_host (
    .clock(clock), .spi_csn(spi_csn), .spi_sck(spi_sck),
    .spi_mosi(spi_mosi), .spi_miso(spi_miso));
  // Expected status: count, tx state 6, bus active level, fault, drop.
  // The tx state is not a palindrome, so a reversed field shows up.
  function automatic mrb_byte_t stat(input logic [1:0] c,
                                     input logic f, input logic d);
    return {c, 3'h6, bus_active, f, d};
  endfunction
  task automatic chk(input string nm, input logic [7:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic complete_run;
    $display("checked %0d n_errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Three-byte message: type, target, source.
  task automatic send(input mrb_byte_t b0, b1, b2, input logic err);
    mrb_byte_t m [3];
    m = '{b0, b1, b2};
    for (int i = 0; i < 3; i++) begin
      in_valid <= 1'b1;
      in_data <= m[i];
      in_last <= (i == 2);
      in_err <= err;
      // Ready seen between edges tells whether the next edge takes the byte.
      @(negedge clock);
      for (int k = 0; k < 50 && in_ready !== 1'b1; k++)
        @(negedge clock);
      @(posedge clock);
    end
    in_valid <= 1'b0;
  endtask
  // Idle status frame with the bus quiet; an unknown command returns zero.
  task automatic t_reset;
    i_mrb_host.xfer(8'h00, st, dat);
    chk("idle status", st, stat(2'h0, 1'b0, 1'b0));
    chk("idle data", dat, 8'h00);
    bus_active <= 1'b1;
  endtask
  // Bad and filtered messages never reach the host.
  task automatic t_drop;
    send(8'h04, 8'h2A, 8'h55, 1'b1);
    send(8'h04, 8'h5A, 8'h55, 1'b0);
    bus_fault <= 1'b1;
    @(posedge clock);
    bus_fault <= 1'b0;
    repeat (20) @(posedge clock);
    chk("irq drop", msg_irq, 1'b0);
    i_mrb_host.xfer(8'h00, st, dat);
    chk("error status", st, stat(2'h0, 1'b1, 1'b1));
  endtask
  // Good message raises irq and reads back in order.
  task automatic t_msg;
    mrb_byte_t m [3];
    m = '{8'h04, 8'h2A, 8'h55};
    send(m[0], m[1], m[2], 1'b0);
    for (int k = 0; k < 10 && msg_irq !== 1'b1; k++)
      @(posedge clock);
    chk("irq set", msg_irq, 1'b1);
    for (int i = 0; i < 3; i++) begin
      i_mrb_host.xfer(`MRB_CMD_READ, st, dat);
      chk("read status", st, stat(2'h1, 1'b0, 1'b0));
      chk("read data", dat, m[i]);
    end
    chk("irq freed", msg_irq, 1'b0);
  endtask
  // Fill both buffers and the queue, then flush the oldest.
  task automatic t_fill;
    send(8'h01, 8'h2A, 8'h11, 1'b0);
    send(8'h02, 8'h2A, 8'h22, 1'b0);
    repeat (30) @(posedge clock);
    n = 0;
    in_valid <= 1'b1;
    in_last <= 1'b0;
    in_data <= 8'h33;
    // Ready is read between edges, so each count is one byte taken.
    for (int k = 0; k < 12; k++) begin
      @(negedge clock);
      if (in_ready === 1'b1) n++;
      @(posedge clock);
    end
    in_valid <= 1'b0;
    chk("queue depth", n[7:0], `MRB_FIFO_D);
    i_mrb_host.xfer(`MRB_CMD_FLUSH, st, dat);
    chk("full status", st, stat(2'h2, 1'b0, 1'b0));
    chk("ready back", in_ready, 1'b1);
    chk("irq kept", msg_irq, 1'b1);
    i_mrb_host.xfer(`MRB_CMD_READ, st, dat);
    chk("after flush", st, stat(2'h1, 1'b0, 1'b0));
    chk("next head", dat, 8'h02);
  endtask
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  // Watchdog sized for seven link frames plus margin.
  initial begin
    repeat (80000) @(posedge clock);
    n_errors++;
    complete_run();
  end
  initial begin
    rstn = 1'b0;
    in_valid = 1'b0;
    in_data = 8'h00;
    in_last = 1'b0;
    in_err = 1'b0;
    bus_fault = 1'b0;
    bus_active = 1'b0;
    n_errors = 0;
    checked = 0;
    repeat (10) @(posedge clock);
    rstn <= 1'b1;
    @(posedge clock);
    t_reset();
    t_drop();
    t_msg();
    t_fill();
    complete_run();
  end
endmodule
`default_nettype wire
